// *** core/lpwc_top.v ***
// Purpose: wait/stop mode control, wake selection and stop recovery
// Assumes: crystal clock edge arrives as an async pin, synchronised here
// Notes:   clock gates are enables for the clock tree, all registered
// Functional notes
// [RULE1] DMA keeps running in wait when its wait enable is set
// [RULE2] Without wait enable, wait suspends DMA; resume on exit if priority
// [RULE3] Stop suspends DMA; interrupt exit resumes if priority, reset aborts
// [RULE4] Software finishes DMA and clears channel enables, or clears mask
// [RULE5] External interrupt lines stay live and wake from wait or stop
// [RULE6] Keypad unit stays live and wakes from wait or stop when unmasked
// [RULE7] Enabled undervoltage monitor runs in low power; its reset wakes
// [RULE8] Serial units and timer run in wait; their interrupts wake wait
// [RULE9] Async serial unit halts in stop, keeps registers, resumes after
// [RULE10] SPI halts in stop; resumes on interrupt, reset on reset exit
// [RULE11] Timer freezes in stop and resumes on interrupt exit
// [RULE12] Pin, watchdog or undervoltage reset ends wait with reset vector
// [RULE13] External line or keypad edge wakes with its own vector
// [RULE14] Break interrupt ends wait or stop with break vector
// [RULE15] Clock generator and DMA interrupts wake wait with their vectors
// [RULE16] Timer interrupts wake wait with overflow and channel vectors
// [RULE17] SPI transmit and receive interrupts wake wait with vectors
// [RULE18] Async serial transmit, receive, error interrupts wake wait
// [RULE19] Only reset, edge, undervoltage or break ends stop
// [RULE20] Recovery counter holds clocks for crystal cycles after stop wake
// [RULE21] Build option picks 4096 or 32 crystal cycle recovery
// [RULE22] Wait gates CPU clock only; stop gates CPU and bus clocks
// [RULE23] Entry clears interrupt mask; reset exit sets it again
// [RULE24] Stop disables clock generator and falls back to crystal/2
`timescale 1ns/1ps
`default_nettype none
`include "lpwc_defines.vh"
module lpwc_top #(
  parameter        LONG_RECOVERY = 1,
  parameter [12:0] REC_LONG      = `LPWC_REC_LONG,
  parameter [12:0] REC_SHORT     = `LPWC_REC_SHORT
) (
  // Clock and reset
  input  wire        CORE_CLK,
  input  wire        NRST,
  // CPU requests, one-cycle pulses
  input  wire        WAIT_REQ,
  input  wire        STOP_REQ,
  input  wire        VEC_ACK,
  // Reset sources, async levels, active low pin
  input  wire        RST_PIN_N,
  input  wire        WDOG_TIMEOUT,
  input  wire        UV_TRIP,
  input  wire        UV_ENABLE,
  input  wire        UV_RESET_ENABLE,
  // External and keypad pins, async, active low
  input  wire        EXT_INT_LINE_ONE_N,
  input  wire        EXT_INT_LINE_TWO_N,
  input  wire        KEYPAD_N,
  input  wire        EXT_LINE_ONE_MASK,
  input  wire        EXT_LINE_TWO_MASK,
  input  wire        KEYPAD_INT_MASK,
  // Internal interrupt requests, enabled levels
  input  wire        BREAK_INT,
  input  wire        CLKGEN_INT,
  input  wire        DMA_INT,
  input  wire [4:0]  TIMER_INT,
  input  wire [1:0]  SPI_INT,
  input  wire [2:0]  ASYNC_INT,
  // DMA control
  input  wire        DMA_WAIT_ENABLE,
  input  wire        DMA_PRIORITY_BIT,
  input  wire        DMA_BUSY,
  // Clock generator state
  input  wire        CRYSTAL_CLOCK,
  input  wire        LOOP_CLK_SELECTED,
  // Outputs
  output reg         CPU_CLK_EN,
  output reg         BUS_CLK_EN,
  output reg         CLKGEN_ENABLE,
  output reg         FORCE_XTAL_DIV2,
  output reg         DMA_RUN,
  output reg         DMA_ABORT,
  output reg         PERIPH_RUN,
  output reg         SPI_RESET,
  output reg         INT_MASK,
  output reg         VEC_VALID,
  output reg  [15:0] VEC_ADDR,
  output reg  [1:0]  MODE
);

  reg [1:0]  state_ff;
  reg [1:0]  nxt_state;
  reg [12:0] rec_cnt_ff;
  reg [12:0] nxt_rec_cnt;
  reg        dma_resume_ff;
  reg        nxt_dma_resume;
  reg        pend_reset_ff;
  reg [15:0] nxt_vec;
  reg        nxt_vec_valid;
  reg [6:0]  s1_ff;
  reg [6:0]  s2_ff;
  reg [6:0]  s3_ff;

  wire rst_pin  = s2_ff[0];
  wire wdog     = s2_ff[1];
  wire uv       = s2_ff[2];
  wire line1    = s2_ff[3];
  wire line2    = s2_ff[4];
  wire keypad   = s2_ff[5];
  wire xtal     = s2_ff[6];
  wire xtal_rise = xtal & ~s3_ff[6];
  // Falling pin edges, pins seen inverted after sync
  wire e1 = line1 & ~s3_ff[3] & ~EXT_LINE_ONE_MASK;          // [RULE5] [RULE13]
  wire e2 = line2 & ~s3_ff[4] & ~EXT_LINE_TWO_MASK;          // [RULE5] [RULE13]
  wire ek = keypad & ~s3_ff[5] & ~KEYPAD_INT_MASK;           // [RULE6] [RULE13]
  wire uv_rst = uv & UV_ENABLE & UV_RESET_ENABLE;            // [RULE7]
  wire any_rst = rst_pin | wdog | uv_rst;                    // [RULE12]
  wire stop_rst = rst_pin | uv_rst;                          // [RULE19]
  wire ext_edge = e1 | e2 | ek;
  // Peripheral requests count in wait only; their clock is off in stop
  wire periph_int = CLKGEN_INT | DMA_INT | (|TIMER_INT) |
                    (|SPI_INT) | (|ASYNC_INT);               // [RULE8]
  wire wait_int   = ext_edge | BREAK_INT | periph_int;       // [RULE8]
  wire stop_wake = stop_rst | ext_edge | BREAK_INT;          // [RULE19]
  wire [12:0] rec_len = LONG_RECOVERY ? REC_LONG : REC_SHORT; // [RULE21]
  // Mode transitions shared by several registers
  wire enter_low = (state_ff == `LPWC_ST_RUN) & (WAIT_REQ | STOP_REQ);
  wire wait_rst  = (state_ff == `LPWC_ST_WAIT) & any_rst;
  wire rec_done  = (state_ff == `LPWC_ST_RECOVER) &
                   (nxt_state == `LPWC_ST_RUN);

  // Fixed priority, reset first, then highest vector address
  function [15:0] pick_vec;
    input rst;
    input in_wait;
    begin
      if (rst)                          pick_vec = `LPWC_VEC_RESET;  // [RULE12]
      else if (BREAK_INT)               pick_vec = `LPWC_VEC_BREAK;  // [RULE14]
      else if (e1)                      pick_vec = `LPWC_VEC_LINE1;
      else if (in_wait & CLKGEN_INT)    pick_vec = `LPWC_VEC_CLKGEN; // [RULE15]
      else if (in_wait & DMA_INT)       pick_vec = `LPWC_VEC_DMA;    // [RULE15]
      else if (in_wait & TIMER_INT[0])  pick_vec = `LPWC_VEC_TCH0;   // [RULE16]
      else if (in_wait & TIMER_INT[1])  pick_vec = `LPWC_VEC_TCH1;
      else if (in_wait & TIMER_INT[2])  pick_vec = `LPWC_VEC_TCH2;
      else if (in_wait & TIMER_INT[3])  pick_vec = `LPWC_VEC_TCH3;
      else if (in_wait & TIMER_INT[4])  pick_vec = `LPWC_VEC_TOVF;
      else if (in_wait & SPI_INT[1])    pick_vec = `LPWC_VEC_SRX;    // [RULE17]
      else if (in_wait & SPI_INT[0])    pick_vec = `LPWC_VEC_STX;    // [RULE17]
      else if (in_wait & ASYNC_INT[2])  pick_vec = `LPWC_VEC_AERR;   // [RULE18]
      else if (in_wait & ASYNC_INT[1])  pick_vec = `LPWC_VEC_ARX;    // [RULE18]
      else if (in_wait & ASYNC_INT[0])  pick_vec = `LPWC_VEC_ATX;    // [RULE18]
      else if (e2)                      pick_vec = `LPWC_VEC_LINE2;
      else                              pick_vec = `LPWC_VEC_KEYPAD;
    end
  endfunction

  // Bus clock and peripherals live in run and wait only
  function bus_live;
    input [1:0] st;
    begin
      bus_live = (st == `LPWC_ST_RUN) | (st == `LPWC_ST_WAIT);
    end
  endfunction

  always @* begin
    nxt_state      = state_ff;
    nxt_rec_cnt    = rec_cnt_ff;
    nxt_dma_resume = dma_resume_ff;
    nxt_vec        = VEC_ADDR;
    nxt_vec_valid  = VEC_VALID & ~VEC_ACK;
    case (state_ff)
      `LPWC_ST_RUN: begin
        if (STOP_REQ) begin
          nxt_state      = `LPWC_ST_STOP;
          nxt_dma_resume = DMA_BUSY;                         // [RULE3]
        end else if (WAIT_REQ) begin
          nxt_state      = `LPWC_ST_WAIT;
          nxt_dma_resume = DMA_BUSY & ~DMA_WAIT_ENABLE;      // [RULE2]
        end
      end
      `LPWC_ST_WAIT: begin
        if (any_rst | wait_int) begin                        // [RULE12] [RULE8]
          nxt_state     = `LPWC_ST_RUN;
          nxt_vec       = pick_vec(any_rst, 1'b1);
          nxt_vec_valid = 1'b1;
        end
      end
      `LPWC_ST_STOP: begin
        if (stop_wake) begin                                 // [RULE19]
          nxt_state   = `LPWC_ST_RECOVER;
          nxt_rec_cnt = rec_len;                             // [RULE20]
          nxt_vec     = pick_vec(stop_rst, 1'b0);
        end
      end
      `LPWC_ST_RECOVER: begin
        // Counts crystal edges only, so the core clock rate does not matter
        if (xtal_rise)
          nxt_rec_cnt = rec_cnt_ff - 13'h0001;               // [RULE20]
        if (rec_cnt_ff == 13'h0001 && xtal_rise) begin
          nxt_state     = `LPWC_ST_RUN;
          nxt_vec_valid = 1'b1;
        end
      end
      default: nxt_state = `LPWC_ST_RUN;
    endcase
  end

  // Third stage feeds the edge detectors only, never the first
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s1_ff <= 7'h00;
      s2_ff <= 7'h00;
      s3_ff <= 7'h00;
    end else begin
      s1_ff <= {CRYSTAL_CLOCK, ~KEYPAD_N, ~EXT_INT_LINE_TWO_N,
                ~EXT_INT_LINE_ONE_N, UV_TRIP, WDOG_TIMEOUT, ~RST_PIN_N};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state_ff      <= `LPWC_ST_RUN;
      rec_cnt_ff    <= 13'h0000;
      dma_resume_ff <= 1'b0;
      pend_reset_ff <= 1'b0;
      MODE          <= `LPWC_ST_RUN;
    end else begin
      state_ff      <= nxt_state;
      rec_cnt_ff    <= nxt_rec_cnt;
      dma_resume_ff <= nxt_dma_resume;
      MODE          <= nxt_state;
      // Cleared on entry so a later wait exit never sees a stale reset
      if (enter_low)
        pend_reset_ff <= 1'b0;
      else if (state_ff == `LPWC_ST_STOP && stop_wake)
        pend_reset_ff <= stop_rst;
    end
  end

  // Vector handshake, held until the CPU acknowledges
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      VEC_VALID <= 1'b0;
      VEC_ADDR  <= `LPWC_VEC_RESET;
    end else begin
      VEC_VALID <= nxt_vec_valid;
      VEC_ADDR  <= nxt_vec;
    end
  end

  // Clock tree enables
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      CPU_CLK_EN      <= 1'b1;
      BUS_CLK_EN      <= 1'b1;
      CLKGEN_ENABLE   <= 1'b1;
      FORCE_XTAL_DIV2 <= 1'b0;
      PERIPH_RUN      <= 1'b1;
    end else begin
      // Wait keeps bus clock so peripherals run, and DMA when its wait enable is set
      CPU_CLK_EN    <= (nxt_state == `LPWC_ST_RUN);          // [RULE22]
      BUS_CLK_EN    <= bus_live(nxt_state);                  // [RULE22]
      CLKGEN_ENABLE <= (nxt_state != `LPWC_ST_STOP);         // [RULE24]
      // Sticky: the loop clock stays deselected after recovery
      if (state_ff == `LPWC_ST_RUN && STOP_REQ && LOOP_CLK_SELECTED)
        FORCE_XTAL_DIV2 <= 1'b1;                             // [RULE24]
      // Frozen in stop and recovery, registers kept by bus gate
      PERIPH_RUN    <= bus_live(nxt_state);     // [RULE9] [RULE11]
    end
  end

  // DMA run, abort and SPI reset
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      DMA_RUN   <= 1'b1;
      DMA_ABORT <= 1'b0;
      SPI_RESET <= 1'b0;
    end else begin
      if (nxt_state == `LPWC_ST_WAIT)
        DMA_RUN <= DMA_WAIT_ENABLE;                          // [RULE1] [RULE2]
      else if (nxt_state == `LPWC_ST_STOP)
        DMA_RUN <= 1'b0;                                     // [RULE3]
      else if (nxt_state == `LPWC_ST_RUN && state_ff != `LPWC_ST_RUN)
        DMA_RUN <= ~dma_resume_ff | DMA_PRIORITY_BIT |
                   (rec_done & pend_reset_ff) | wait_rst;    // [RULE2] [RULE3]
      DMA_ABORT <= 1'b0;
      SPI_RESET <= 1'b0;
      if (rec_done && pend_reset_ff) begin
        DMA_ABORT <= dma_resume_ff;                          // [RULE3]
        SPI_RESET <= 1'b1;                                   // [RULE10]
      end
      // A reset in wait drops a suspended transfer as well
      if (wait_rst)
        DMA_ABORT <= dma_resume_ff;                          // [RULE12]
    end
  end

  // Interrupt mask, cleared on entry and set again by a reset exit
  always @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST)
      INT_MASK <= 1'b1;
    else if (enter_low)
      INT_MASK <= 1'b0;                                      // [RULE23]
    else if (wait_rst || (rec_done && pend_reset_ff))
      INT_MASK <= 1'b1;                                      // [RULE23]
  end

endmodule // lpwc_top
`default_nettype wire

// *** core/lpwc_defines.vh ***
// Purpose: constants for the low-power wake controller
// Assumes: 16-bit vector addresses, one core clock
// Notes:   vector values name the high byte of each pair
`ifndef LPWC_DEFINES_VH
`define LPWC_DEFINES_VH
`define LPWC_VEC_RESET    16'hfffe
`define LPWC_VEC_BREAK    16'hfffc
`define LPWC_VEC_LINE1    16'hfffa
`define LPWC_VEC_CLKGEN   16'hfff8
`define LPWC_VEC_DMA      16'hfff6
`define LPWC_VEC_TCH0     16'hfff4
`define LPWC_VEC_TCH1     16'hfff2
`define LPWC_VEC_TCH2     16'hfff0
`define LPWC_VEC_TCH3     16'hffee
`define LPWC_VEC_TOVF     16'hffec
`define LPWC_VEC_SRX      16'hffea
`define LPWC_VEC_STX      16'hffe8
`define LPWC_VEC_AERR     16'hffe6
`define LPWC_VEC_ARX      16'hffe4
`define LPWC_VEC_ATX      16'hffe2
`define LPWC_VEC_LINE2    16'hffe0
`define LPWC_VEC_KEYPAD   16'hffde
`define LPWC_REC_LONG     13'h1000
`define LPWC_REC_SHORT    13'h0020
`define LPWC_ST_RUN       2'h0
`define LPWC_ST_WAIT      2'h1
`define LPWC_ST_STOP      2'h2
`define LPWC_ST_RECOVER   2'h3
`endif

// *** verif/lpwc_assertions.sv ***
// Purpose: port timing checks for the wake controller
// Assumes: one core clock, NRST async active low
// Notes:   recovery length and vectors are measured by the bench
`timescale 1ns/1ps
`default_nettype none
module lpwc_chk (
  // Clock and reset
  input wire logic        CORE_CLK,
  input wire logic        NRST,
  // Requests
  input wire logic        WAIT_REQ,
  input wire logic        STOP_REQ,
  input wire logic        VEC_ACK,
  input wire logic        DMA_WAIT_ENABLE,
  // Outputs watched
  input wire logic        CPU_CLK_EN,
  input wire logic        BUS_CLK_EN,
  input wire logic        CLKGEN_ENABLE,
  input wire logic        DMA_RUN,
  input wire logic        PERIPH_RUN,
  input wire logic        INT_MASK,
  input wire logic        VEC_VALID,
  input wire logic [15:0] VEC_ADDR,
  input wire logic [1:0]  MODE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  wait_gate_a: assert property (
    MODE == 2'h0 && WAIT_REQ && !STOP_REQ |=> MODE == 2'h1 && !CPU_CLK_EN
    && BUS_CLK_EN && !INT_MASK) else $error("wait entry gating wrong");
  wait_dma_a: assert property (
    MODE == 2'h0 && WAIT_REQ && !STOP_REQ && DMA_WAIT_ENABLE |=> DMA_RUN)
    else $error("dma halted in wait");
  stop_gate_a: assert property (
    MODE == 2'h0 && STOP_REQ |=> MODE == 2'h2 && !CPU_CLK_EN && !BUS_CLK_EN
    && !CLKGEN_ENABLE && !INT_MASK) else $error("stop entry gating wrong");
  stop_exit_a: assert property (
    MODE == 2'h2 |=> MODE == 2'h2 || MODE == 2'h3)
    else $error("stop left without recovery");
  rec_hold_a: assert property (
    MODE == 2'h3 |-> !CPU_CLK_EN && !BUS_CLK_EN && CLKGEN_ENABLE)
    else $error("clocks released during recovery");
  wait_live_a: assert property (
    MODE == 2'h1 |-> BUS_CLK_EN && PERIPH_RUN) else $error("wait halted units");
  vec_hold_a: assert property (
    VEC_VALID && !VEC_ACK |=> VEC_VALID && $stable(VEC_ADDR))
    else $error("vector dropped before ack");
  ack_clear_a: assert property (
    VEC_VALID && VEC_ACK |=> !VEC_VALID) else $error("vector kept after ack");
  stop_halt_a: assert property (
    MODE == 2'h2 |-> !PERIPH_RUN && !DMA_RUN) else $error("units run in stop");
endmodule // lpwc_chk
bind lpwc_top lpwc_chk u_chk (.*);
`default_nettype wire

// *** verif/lpwc_cpu_model.sv ***
// Purpose: CPU side partner, takes vectors and makes the crystal clock
// Assumes: ack delay set by the bench, crystal at one sixth of core
// Notes:   a slow ack keeps the vector standing for several cycles
`timescale 1ns/1ps
`default_nettype none
module lpwc_cpu_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Vector handshake
  input  wire logic        vec_valid,
  input  wire logic [15:0] vec_addr,
  input  wire logic [3:0]  ack_dly,
  output var  logic        vec_ack,
  output var  logic [15:0] got_vec,
  // Crystal clock
  output var  logic        xtal
);
  logic [3:0] wait_ff;
  logic [1:0] div_ff;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {vec_ack, got_vec, xtal, wait_ff, div_ff} <= '0;
    end else begin
      div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
      xtal <= (div_ff == 2'h2) ? ~xtal : xtal;
      vec_ack <= 1'b0;
      if (vec_valid && !vec_ack) begin
        wait_ff <= (wait_ff == ack_dly) ? 4'h0 : wait_ff + 4'h1;
        vec_ack <= (wait_ff == ack_dly);
        got_vec <= vec_addr; // Fetch of the vector pair
      end
    end
  end
endmodule // lpwc_cpu_model
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: directed wait and stop wake sequences with vector checks
// Assumes: recovery shortened to 8 crystal edges
// Notes:   each wake releases its cause right after the vector appears
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, nrst = 0, wreq = 0, sreq = 0, rpin_n = 1, wdog = 0, uv = 0;
  logic uv_en = 1, dwe = 0, dpri = 0, dbusy = 0, loopsel = 0, sa = 0, ss = 0;
  logic [2:0] pins_n = 3'h7, mask = 3'h0;
  logic [12:0] src = 13'h0;
  logic [3:0] dly = 4'h0;
  wire ack, xtal, cpu_en, bus_en, cg_en, fx2, drun, dab, prun, srst, imask, vv;
  wire [15:0] vaddr, got;
  wire [1:0] mode;
  wire vvs;
  int fails = 0, n_tests = 0, cnt, lead;
  logic [15:0] vtab [13] = '{16'hfffc, 16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2,
    16'hfff0, 16'hffee, 16'hffec, 16'hffe8, 16'hffea, 16'hffe2, 16'hffe4,
    16'hffe6};
  always #2 clk = ~clk;
  always @(posedge clk) begin
    sa <= sa | dab;
    ss <= ss | srst;
  end
  lpwc_top #(.REC_LONG(13'h0008)) u_dut (.CORE_CLK(clk), .NRST(nrst),
    .WAIT_REQ(wreq), .STOP_REQ(sreq), .VEC_ACK(ack), .RST_PIN_N(rpin_n),
    .WDOG_TIMEOUT(wdog), .UV_TRIP(uv), .UV_ENABLE(uv_en),
    .UV_RESET_ENABLE(uv_en), .EXT_INT_LINE_ONE_N(pins_n[0]),
    .EXT_INT_LINE_TWO_N(pins_n[1]), .KEYPAD_N(pins_n[2]),
    .EXT_LINE_ONE_MASK(mask[0]), .EXT_LINE_TWO_MASK(mask[1]),
    .KEYPAD_INT_MASK(mask[2]), .BREAK_INT(src[0]), .CLKGEN_INT(src[1]),
    .DMA_INT(src[2]), .TIMER_INT(src[7:3]), .SPI_INT(src[9:8]),
    .ASYNC_INT(src[12:10]), .DMA_WAIT_ENABLE(dwe), .DMA_PRIORITY_BIT(dpri),
    .DMA_BUSY(dbusy), .CRYSTAL_CLOCK(xtal), .LOOP_CLK_SELECTED(loopsel),
    .CPU_CLK_EN(cpu_en), .BUS_CLK_EN(bus_en), .CLKGEN_ENABLE(cg_en),
    .FORCE_XTAL_DIV2(fx2), .DMA_RUN(drun), .DMA_ABORT(dab), .PERIPH_RUN(prun),
    .SPI_RESET(srst), .INT_MASK(imask), .VEC_VALID(vv), .VEC_ADDR(vaddr),
    .MODE(mode));
  // Same stimulus with the short recovery selected
  lpwc_top #(.LONG_RECOVERY(0), .REC_SHORT(13'h0004)) u_short (
    .CORE_CLK(clk), .NRST(nrst), .WAIT_REQ(wreq), .STOP_REQ(sreq),
    .VEC_ACK(ack), .RST_PIN_N(rpin_n), .WDOG_TIMEOUT(wdog), .UV_TRIP(uv),
    .UV_ENABLE(uv_en), .UV_RESET_ENABLE(uv_en),
    .EXT_INT_LINE_ONE_N(pins_n[0]), .EXT_INT_LINE_TWO_N(pins_n[1]),
    .KEYPAD_N(pins_n[2]), .EXT_LINE_ONE_MASK(mask[0]),
    .EXT_LINE_TWO_MASK(mask[1]), .KEYPAD_INT_MASK(mask[2]),
    .BREAK_INT(src[0]), .CLKGEN_INT(src[1]), .DMA_INT(src[2]),
    .TIMER_INT(src[7:3]), .SPI_INT(src[9:8]), .ASYNC_INT(src[12:10]),
    .DMA_WAIT_ENABLE(dwe), .DMA_PRIORITY_BIT(dpri), .DMA_BUSY(dbusy),
    .CRYSTAL_CLOCK(xtal), .LOOP_CLK_SELECTED(loopsel), .CPU_CLK_EN(),
    .BUS_CLK_EN(), .CLKGEN_ENABLE(), .FORCE_XTAL_DIV2(), .DMA_RUN(),
    .DMA_ABORT(), .PERIPH_RUN(), .SPI_RESET(), .INT_MASK(),
    .VEC_VALID(vvs), .VEC_ADDR(), .MODE());
  lpwc_cpu_model u_cpu (.clk(clk), .nrst(nrst), .vec_valid(vv),
    .vec_addr(vaddr), .ack_dly(dly), .vec_ack(ack), .got_vec(got), .xtal(xtal));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize;
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Cause c: pins [2:0], reset pin, watchdog, undervoltage
  task automatic wake(input logic st, input logic [12:0] s,
      input logic [5:0] c, input logic [15:0] e, input logic im);
    @(posedge clk);
    wreq <= !st;
    sreq <= st;
    @(posedge clk);
    {wreq, sreq} <= 2'b00;
    repeat (2) @(posedge clk);
    {src, pins_n, rpin_n, wdog, uv} <= {s, ~c[2:0], !c[3], c[4], c[5]};
    cnt = 0;
    lead = 0;
    #1;
    while (vv !== 1'b1 && cnt < 400) begin
      @(posedge clk);
      #1;
      cnt++;
      if (vv !== 1'b1 && vvs === 1'b1)
        lead++;
    end
    if (cnt >= 400) begin
      fails++;
      summarize();
    end
    chk(vaddr, e);
    chk({15'h0, imask}, {15'h0, im});
    // 8 crystal edges of 6 core cycles, plus sync and phase
    chk({15'h0, st ? (cnt > 42 && cnt < 53) : (cnt < 12)}, 16'h1);
    // Short option ends 4 crystal edges earlier
    chk(16'(lead), st ? 16'h0018 : 16'h0000);
    @(posedge clk);
    {src, pins_n, rpin_n, wdog, uv} <= {13'h0, 3'h7, 1'b1, 2'b00};
    repeat (6) @(posedge clk);
    chk(got, e);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({13'h0, imask, mode}, 16'h0004);
    for (int i = 0; i < 13; i++) begin
      dly <= 4'(i % 4);
      wake(0, 13'h1 << i, 6'h0, vtab[i], 0);
    end
    wake(0, 13'h0, 6'h01, 16'hfffa, 0);
    wake(0, 13'h0, 6'h02, 16'hffe0, 0);
    wake(0, 13'h0, 6'h08, 16'hfffe, 1);
    wake(0, 13'h0, 6'h10, 16'hfffe, 1);
    wake(0, 13'h0, 6'h20, 16'hfffe, 1);
    loopsel <= 1'b1;
    wake(1, 13'h80, 6'h14, 16'hffde, 0);
    chk({15'h0, fx2}, 16'h1);
    {mask, loopsel} <= 4'h2;
    wake(1, 13'h0, 6'h05, 16'hffde, 0);
    mask <= 3'h0;
    wake(1, 13'h0, 6'h02, 16'hffe0, 0);
    wake(1, 13'h1, 6'h0, 16'hfffc, 0);
    uv_en <= 1'b0;
    wake(1, 13'h0, 6'h21, 16'hfffa, 0);
    uv_en <= 1'b1;
    {dbusy, dwe} <= 2'b11;
    wake(0, 13'h4, 6'h0, 16'hfff6, 0);
    dwe <= 1'b0;
    wake(0, 13'h4, 6'h0, 16'hfff6, 0);
    chk({15'h0, drun}, 16'h0);
    dpri <= 1'b1;
    wake(0, 13'h4, 6'h0, 16'hfff6, 0);
    chk({15'h0, drun}, 16'h1);
    wake(1, 13'h0, 6'h08, 16'hfffe, 1);
    chk({14'h0, sa, ss}, 16'h3);
    dbusy <= 1'b0; // Transfer finished before stop
    wake(1, 13'h0, 6'h20, 16'hfffe, 1);
    summarize();
  end
endmodule // testbench
`default_nettype wire
